//--- rtl/scc_pkg.sv
/*
 * constants for the sync, clamp and coast input control block.
 * assumes a 125 MHz clk and asynchronous active-low reset.
 */
package scc_pkg;

    // =========================================================
    // polarity field encodings (2-bit fields)
    localparam logic [1:0] POL_AUTO_A = 2'h0; // automatic detection
    localparam logic [1:0] POL_AUTO_B = 2'h1; // automatic detection
    localparam logic [1:0] POL_LOW = 2'h2; // manual, active low
    localparam logic [1:0] POL_HIGH = 2'h3; // manual, active high

    // =========================================================
    // slicer threshold: code n means (n+1)*8 mV, 5 bits
    localparam int THR_STEP_MV = 8;
    localparam int THR_MIN_MV = 8;
    localparam int THR_MAX_MV = 256;
    localparam int THR_DEF_MV = 128;
    localparam logic [4:0] THR_DEF_CODE = 5'((THR_DEF_MV - THR_MIN_MV) / THR_STEP_MV);

    // =========================================================
    // field positions of the settings words
    localparam int FS_POL_LSB = 4; // frame sync polarity bits[5:4]
    localparam int CLP_FUNC_BIT = 4; // clamp function enable
    localparam int CLP_POL_LSB = 6; // clamp/coast polarity bits[7:6]
    localparam int EXTERNAL_PIXEL_CLOCK_IN_BIT = 2; // external clock enable
    localparam int PD_POL_BIT = 2; // sleep pin polarity
    localparam int PD_CTRL_BIT = 3; // power-down control bit
    localparam int PD_MODE_BIT = 4; // manual power-down select

    // reset values
    localparam logic CLP_FUNC_RST = 1'b0;
    localparam logic COAST_POL_RST = 1'b1;

    // =========================================================
    // auto polarity: window of samples for majority estimation
    localparam int AUTO_WIN_W = 10;
    localparam logic [AUTO_WIN_W-1:0] AUTO_WIN_LAST = 10'h3FF;

    // internal clamp default delay and duration in clk cycles
    localparam logic [7:0] CLP_DLY_RST = 8'h04;
    localparam logic [7:0] CLP_DUR_RST = 8'h10;

endpackage : scc_pkg

//--- rtl/scc_pol.sv
/*
 * one polarity stage: two-flop synchroniser, automatic sense detection,
 * conditional inversion and edge detection of the normalised strobe.
 * assumes the raw input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module scc_pol
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic raw_in,
    input wire logic [1:0] pol_sel,
    input wire logic pol_rst_high,
    output logic act_out,
    output logic lead_out,
    output logic trail_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic act;
        logic [AUTO_WIN_W-1:0] cnt;
        logic [AUTO_WIN_W-1:0] high_cnt;
        logic auto_flip; // estimate differs from power-up sense
        logic [1:0] warm;
    } scc_pol_st_t;

    scc_pol_st_t st_ff;
    scc_pol_st_t nxt_st;
    logic sense_high;

    // =========================================================
    // sense: manual fields, or estimated one where the strobe is the rare level
    always_comb begin
        unique case (pol_sel)
            POL_LOW: sense_high = 1'b0;
            POL_HIGH: sense_high = 1'b1;
            default: sense_high = st_ff.auto_flip ^ pol_rst_high;
        endcase
    end

    // next state: sync, count, invert
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = raw_in;
        nxt_st.s2 = st_ff.s1;
        // strobe held idle until both sync flops carry pin samples
        nxt_st.warm = st_ff.warm[1] ? st_ff.warm : st_ff.warm + 2'h1;
        nxt_st.act = st_ff.warm[1] & (sense_high ? st_ff.s2 : ~st_ff.s2); // R21
        nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.high_cnt = st_ff.high_cnt + {{(AUTO_WIN_W-1){1'b0}}, st_ff.s2};
        if (st_ff.cnt == AUTO_WIN_LAST) begin
            // mostly high means pulses are low
            nxt_st.auto_flip = ~st_ff.high_cnt[AUTO_WIN_W-1] ^ pol_rst_high;
            nxt_st.high_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign act_out = st_ff.act;
    assign lead_out = nxt_st.act & ~st_ff.act;
    assign trail_out = ~nxt_st.act & st_ff.act;

endmodule : scc_pol

`default_nettype wire

//--- rtl/scc_top.sv
/*
 * sync, clamp and coast input control for a video capture front end.
 * assumes all pins asynchronous to clk; settings are static plain ports.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: frame sync sense automatic or from field
// R2: frame sync times field and freewheel interval
// R3: slicer threshold 8..256 mV, default 128
// R4: slicer output is non-inverted detected sync
// R5: clamp strobe honoured only when enable set
// R6: enable clear: internal delay/duration clamp
// R7: external clamp exactly while strobe active
// R8: clamp strobe sense automatic or from field
// R9: source asserts clamp during back porch
// R10: external clock enable selects shared pin
// R11: freewheel holds pixel clock frequency, phase
// R12: freewheel sense automatic or from field
// R13: freewheel polarity powers up as one
// R14: shared pin functions do not interfere
// R15: unused shared pin tied low, polarity one
// R16: power-down from pin with control bit
// R17: mode select and pin polarity bits
// R18: unused sleep pin: active high, pulled low
// R19: line sync lead to clock, trail clamp
// R20: line polarity 0 falling, 1 rising
// R21: polarity applied by inversion before edges
module scc_top
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_sync_in_a,
    input wire logic frame_sync_in_b,
    input wire logic embedded_sync_in_a,
    input wire logic embedded_sync_in_b,
    input wire logic line_sync_in,
    input wire logic clamp_strobe_in,
    input wire logic external_pixel_clock_in,
    input wire logic sleep_control_pin,
    input wire logic input_select,
    input wire logic [7:0] frame_sync_cfg,
    input wire logic line_sync_pol,
    input wire logic [7:0] clamp_cfg,
    input wire logic [7:0] clock_cfg,
    input wire logic [7:0] power_cfg,
    input wire logic [4:0] slicer_thr_code,
    input wire logic slicer_thr_load,
    input wire logic [7:0] clamp_delay,
    input wire logic [7:0] clamp_duration,
    output logic slicer_sync_out,
    output logic [8:0] slicer_thr_mv,
    output logic odd_field,
    output logic frame_start,
    output logic freewheel,
    output logic pll_track_pulse,
    output logic clamp_active,
    output logic use_external_clock,
    output logic ext_clock_level,
    output logic powered_down
);

    typedef struct packed {
        logic [4:0] thr;
        logic clp_en;
        logic field;
        logic fw;
        logic track;
        logic clamp;
        logic [7:0] clp_cnt;
        logic clp_wait;
        logic clp_run;
        logic slice;
        logic ext_sel;
        logic ck1;
        logic ck2;
        logic pd;
        logic pd1;
        logic pd2;
        logic sg1;
        logic sg2;
    } scc_st_t;

    scc_st_t st_ff;
    scc_st_t nxt_st;

    logic fs_raw;
    logic fs_act;
    logic fs_lead;
    logic ls_lead;
    logic ls_trail;
    logic cl_act;
    logic cw_act;
    logic [1:0] line_pol_sel;
    logic [1:0] coast_pol_sel;
    logic pin_on;

    // =========================================================
    // polarity stages
    assign fs_raw = input_select ? frame_sync_in_b : frame_sync_in_a;
    assign line_pol_sel = line_sync_pol ? POL_HIGH : POL_LOW; // R20

    scc_pol u_fs (
        .clk(clk),
        .reset_n(reset_n),
        .raw_in(fs_raw),
        .pol_sel(frame_sync_cfg[FS_POL_LSB +: 2]), // R1
        .pol_rst_high(1'b1),
        .act_out(fs_act),
        .lead_out(fs_lead),
        .trail_out()
    );

    scc_pol u_ls (
        .clk(clk),
        .reset_n(reset_n),
        .raw_in(line_sync_in),
        .pol_sel(line_pol_sel),
        .pol_rst_high(1'b1),
        .act_out(),
        .lead_out(ls_lead),
        .trail_out(ls_trail)
    );

    scc_pol u_cl (
        .clk(clk),
        .reset_n(reset_n),
        .raw_in(clamp_strobe_in),
        .pol_sel(clamp_cfg[CLP_POL_LSB +: 2]), // R8
        .pol_rst_high(1'b1),
        .act_out(cl_act),
        .lead_out(),
        .trail_out()
    );

    // freewheel shares the pin; polarity taken straight from the clamp
    // polarity field, auto estimate starting from active high
    assign coast_pol_sel = clamp_cfg[CLP_POL_LSB +: 2]; // R12

    scc_pol u_cw (
        .clk(clk),
        .reset_n(reset_n),
        .raw_in(external_pixel_clock_in), // R14
        .pol_sel(coast_pol_sel),
        .pol_rst_high(COAST_POL_RST), // R13
        .act_out(cw_act),
        .lead_out(),
        .trail_out()
    );

    // power-down pin sense from polarity bit
    assign pin_on = power_cfg[PD_POL_BIT] ? st_ff.pd2 : ~st_ff.pd2; // R17

    // =========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        // threshold register, default 128 mV
        if (slicer_thr_load) begin
            nxt_st.thr = slicer_thr_code; // R3
        end
        nxt_st.sg1 = input_select ? embedded_sync_in_b : embedded_sync_in_a;
        nxt_st.sg2 = st_ff.sg1;
        nxt_st.slice = st_ff.sg2; // R4
        nxt_st.clp_en = clamp_cfg[CLP_FUNC_BIT]; // R5
        // field toggles per frame, freewheel spans frame sync
        if (fs_lead) begin
            nxt_st.field = ~st_ff.field; // R2
        end
        nxt_st.fw = fs_act | (~st_ff.ext_sel & cw_act); // R2 R11
        nxt_st.track = ls_lead & ~nxt_st.fw; // R19 R11
        // internal clamp from trailing edge
        if (ls_trail) begin
            nxt_st.clp_wait = 1'b1; // R19
            nxt_st.clp_run = 1'b0;
            nxt_st.clp_cnt = clamp_delay;
        end else if (st_ff.clp_wait) begin
            if (st_ff.clp_cnt == 8'h00) begin
                nxt_st.clp_wait = 1'b0;
                nxt_st.clp_run = 1'b1;
                nxt_st.clp_cnt = clamp_duration;
            end else begin
                nxt_st.clp_cnt = st_ff.clp_cnt - 8'h01;
            end
        end else if (st_ff.clp_run) begin
            if (st_ff.clp_cnt == 8'h00) begin
                nxt_st.clp_run = 1'b0;
            end else begin
                nxt_st.clp_cnt = st_ff.clp_cnt - 8'h01;
            end
        end
        // source select for clamp
        if (st_ff.clp_en) begin
            nxt_st.clamp = cl_act; // R7 R9
        end else begin
            nxt_st.clamp = st_ff.clp_run && st_ff.clp_cnt != 8'h00; // R6
        end
        nxt_st.ext_sel = clock_cfg[EXTERNAL_PIXEL_CLOCK_IN_BIT]; // R10
        nxt_st.ck1 = external_pixel_clock_in;
        nxt_st.ck2 = st_ff.ck1;
        nxt_st.pd1 = sleep_control_pin;
        nxt_st.pd2 = st_ff.pd1;
        // manual mode: pin and bit together; else bit only
        if (power_cfg[PD_MODE_BIT]) begin
            nxt_st.pd = pin_on & power_cfg[PD_CTRL_BIT]; // R16 R18
        end else begin
            nxt_st.pd = power_cfg[PD_CTRL_BIT]; // R16
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.thr <= THR_DEF_CODE;
            st_ff.clp_en <= CLP_FUNC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // outputs
    assign slicer_sync_out = st_ff.slice;
    assign slicer_thr_mv = 9'(({4'h0, st_ff.thr} + 9'h001) * 9'(THR_STEP_MV));
    assign odd_field = st_ff.field;
    assign frame_start = fs_lead;
    assign freewheel = st_ff.fw;
    assign pll_track_pulse = st_ff.track;
    assign clamp_active = st_ff.clamp;
    assign use_external_clock = st_ff.ext_sel;
    assign ext_clock_level = st_ff.ck2 & st_ff.ext_sel;
    assign powered_down = st_ff.pd;

endmodule : scc_top

`default_nettype wire

//--- sim/scc_src.sv
/* video source model: line sync, back-porch clamp strobe, frame sync.
   assumes the bench clock; all lines sit low while run is low. */
`timescale 1ns/1ps
`default_nettype none

module scc_src (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    output logic line_sync,
    output logic clamp_strobe,
    output logic frame_sync
);
    // =========================================================
    // timing of one 64-cycle line, eight lines a frame
    logic [8:0] pos_ff;

    // free-running position counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_ff <= 9'h000;
        end else begin
            pos_ff <= pos_ff + 9'h001;
        end
    end

    // active-high line sync; pin has pull-down, idle low
    assign line_sync = run && (pos_ff[5:0] < 6'h08);
    // strobe only in back porch, after sync trailing edge
    assign clamp_strobe = run && (pos_ff[5:0] >= 6'h0C) && (pos_ff[5:0] < 6'h14);
    // frame sync spans one line lead
    assign frame_sync = run && (pos_ff >= 9'h020) && (pos_ff < 9'h068);
endmodule : scc_src

`default_nettype wire

//--- sim/scc_top_chk.sv
/* port checker for scc_top, bound below.
   assumes settings ports held steady while a property runs. */
`timescale 1ns/1ps
`default_nettype none

module scc_top_chk
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_sync_in_a,
    input wire logic embedded_sync_in_a,
    input wire logic clamp_strobe_in,
    input wire logic external_pixel_clock_in,
    input wire logic sleep_control_pin,
    input wire logic input_select,
    input wire logic [7:0] frame_sync_cfg,
    input wire logic [7:0] clamp_cfg,
    input wire logic [7:0] clock_cfg,
    input wire logic [7:0] power_cfg,
    input wire logic slicer_sync_out,
    input wire logic [8:0] slicer_thr_mv,
    input wire logic odd_field,
    input wire logic frame_start,
    input wire logic freewheel,
    input wire logic pll_track_pulse,
    input wire logic clamp_active,
    input wire logic use_external_clock,
    input wire logic powered_down
);
    // =========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_thr;
        slicer_thr_mv[2:0] == 3'h0 && slicer_thr_mv >= 9'h008 && slicer_thr_mv <= 9'h100;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold off grid");
    property p_slice;
        (!input_select && embedded_sync_in_a) [*6] |-> slicer_sync_out;
    endproperty
    a_slice: assert property (p_slice) else $error("slicer output inverted");
    property p_clp_on;
        clamp_cfg[7:4] == 4'hD && $rose(clamp_strobe_in) |-> ##[2:5] clamp_active;
    endproperty
    a_clp_on: assert property (p_clp_on) else $error("clamp late on");
    property p_clp_off;
        clamp_cfg[7:4] == 4'hD && $fell(clamp_strobe_in) |-> ##[2:5] !clamp_active;
    endproperty
    a_clp_off: assert property (p_clp_off) else $error("clamp late off");
    property p_ext;
        clock_cfg[2] [*5] |-> use_external_clock;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock not used");
    property p_fw;
        (clamp_cfg[7:6] == 2'h3 && !clock_cfg[2] && external_pixel_clock_in) [*6] |-> freewheel;
    endproperty
    a_fw: assert property (p_fw) else $error("freewheel missing");
    property p_share;
        (clock_cfg[2] && frame_sync_cfg[5:4] == 2'h3 && !input_select && !frame_sync_in_a) [*6]
            |-> !freewheel;
    endproperty
    a_share: assert property (p_share) else $error("shared pin leaks");
    property p_pd;
        (power_cfg[4:2] == 3'h7 && sleep_control_pin) [*6] |-> powered_down;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down missing");
    property p_pd_off;
        (power_cfg[4] && !power_cfg[3]) [*6] |-> !powered_down;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("power-down without bit");
    property p_field;
        frame_start |-> ##[0:2] $changed(odd_field);
    endproperty
    a_field: assert property (p_field) else $error("field not toggled");
    property p_trk;
        pll_track_pulse |=> !pll_track_pulse;
    endproperty
    a_trk: assert property (p_trk) else $error("track pulse too long");

    // main scenarios reached
    c_clamp: cover property ($rose(clamp_active) && clamp_cfg[4]);
    c_pd: cover property ($rose(powered_down));
    c_fw: cover property ($rose(freewheel));
endmodule : scc_top_chk

bind scc_top scc_top_chk chk_u (.*);

`default_nettype wire

//--- sim/scc_top_bench.sv
/* self-checking bench for scc_top with a video source model.
   assumes scc_pkg, scc_top and scc_src compiled before. */
`timescale 1ns/1ps
`default_nettype none

module scc_top_bench;
    import scc_pkg::*;
    // =========================================================
    // signals named as the ports, joined by name
    logic clk, reset_n, frame_sync_in_a, frame_sync_in_b, embedded_sync_in_a;
    logic embedded_sync_in_b, line_sync_in, clamp_strobe_in, external_pixel_clock_in;
    logic sleep_control_pin, input_select, line_sync_pol, slicer_thr_load, run;
    logic [7:0] frame_sync_cfg, clamp_cfg, clock_cfg, power_cfg, clamp_delay, clamp_duration;
    logic [4:0] slicer_thr_code;
    logic slicer_sync_out, odd_field, frame_start, freewheel, pll_track_pulse;
    logic clamp_active, use_external_clock, ext_clock_level, powered_down;
    logic [8:0] slicer_thr_mv;
    int n_errors = 0;
    int samples_checked = 0;
    int tick = 0;

    scc_top dut_u (.*);
    scc_src src_u (.clk(clk), .reset_n(reset_n), .run(run), .line_sync(line_sync_in),
        .clamp_strobe(clamp_strobe_in), .frame_sync(frame_sync_in_a));

    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %0d got %0d", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // high cycles of a level over a window
    task automatic hi_count(ref logic s, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            c += int'(s);
        end
    endtask : hi_count

    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // =========================================================
    // scenarios
    task automatic t_reset;
        chk("thr_rst", 9'h080, slicer_thr_mv);
        chk("clamp_rst", 9'h000, {8'h00, clamp_active});
    endtask : t_reset

    task automatic t_thr;
        logic [4:0] codes[3] = '{5'h00, 5'h1F, 5'h0F};
        foreach (codes[i]) begin
            @(posedge clk);
            slicer_thr_code <= codes[i];
            slicer_thr_load <= 1'b1;
            @(posedge clk);
            slicer_thr_load <= 1'b0;
            cyc(3);
            chk("thr_mv", ({4'h0, codes[i]} + 9'h001) * 9'h008, slicer_thr_mv);
        end
    endtask : t_thr

    task automatic t_slicer;
        @(posedge clk);
        embedded_sync_in_a <= 1'b1;
        cyc(6);
        chk("slicer_a", 9'h001, {8'h00, slicer_sync_out});
        @(posedge clk);
        input_select <= 1'b1;
        cyc(6);
        chk("slicer_b", 9'h000, {8'h00, slicer_sync_out});
        @(posedge clk);
        input_select <= 1'b0;
    endtask : t_slicer

    task automatic t_pd;
        logic [7:0] cfgs[4] = '{8'h1C, 8'h1C, 8'h14, 8'h18};
        logic pins[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic exps[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        foreach (cfgs[i]) begin
            @(posedge clk);
            power_cfg <= cfgs[i];
            sleep_control_pin <= pins[i];
            cyc(7);
            chk("powered_down", {8'h00, exps[i]}, {8'h00, powered_down});
        end
        @(posedge clk);
        power_cfg <= 8'h14;
    endtask : t_pd

    task automatic t_ext;
        @(posedge clk);
        clamp_cfg <= 8'hC0;
        external_pixel_clock_in <= 1'b1;
        cyc(7);
        chk("freewheel", 9'h001, {8'h00, freewheel});
        @(posedge clk);
        clock_cfg <= 8'h04;
        cyc(7);
        chk("use_ext", 9'h001, {8'h00, use_external_clock});
        chk("fw_ext_on", 9'h000, {8'h00, freewheel});
        chk("ext_level", 9'h001, {8'h00, ext_clock_level});
        // auto sense: starts active high, a steady high pin then reads idle
        @(posedge clk);
        {clamp_cfg, clock_cfg} <= 16'h0000;
        cyc(8);
        chk("fw_auto_init", 9'h001, {8'h00, freewheel});
        cyc(2100);
        chk("fw_auto_idle", 9'h000, {8'h00, freewheel});
        @(posedge clk);
        clamp_cfg <= 8'hC0;
        external_pixel_clock_in <= 1'b0;
    endtask : t_ext

    task automatic t_clamp;
        logic [7:0] cfgs[3] = '{8'hC0, 8'hD0, 8'h90};
        int exps[3] = '{32, 16, 112};
        int c;
        @(posedge clk);
        run <= 1'b1;
        foreach (cfgs[i]) begin
            @(posedge clk);
            clamp_cfg <= cfgs[i];
            cyc(100);
            hi_count(clamp_active, 128, c);
            chk("clamp_cycles", 9'(exps[i]), 9'(c));
        end
    endtask : t_clamp

    task automatic t_field;
        int c;
        logic f0;
        // freewheel pin back to active high, so it stays inactive
        @(posedge clk);
        clamp_cfg <= 8'hC0;
        cyc(8);
        hi_count(frame_start, 1024, c);
        chk("frame_starts", 9'h002, 9'(c));
        f0 = odd_field;
        hi_count(pll_track_pulse, 512, c);
        chk("track_pulses", 9'h007, 9'(c));
        chk("odd_field", {8'h00, ~f0}, {8'h00, odd_field});
    endtask : t_field

    // track pulse position after frame lead, for each line sync sense
    task automatic t_line_pol;
        logic pols[2] = '{1'b0, 1'b1};
        int c;
        foreach (pols[i]) begin
            @(posedge clk);
            line_sync_pol <= pols[i];
            cyc(8);
            do begin
                cyc(1);
            end while (frame_start !== 1'b1);
            cyc(pols[i] ? 96 : 104);
            hi_count(pll_track_pulse, 2, c);
            chk("track_at_lead", 9'h001, 9'(c));
        end
    endtask : t_line_pol

    // =========================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        {frame_sync_in_b, embedded_sync_in_a, embedded_sync_in_b, run} = 4'h0;
        {external_pixel_clock_in, sleep_control_pin, input_select, slicer_thr_load} = 4'h0;
        line_sync_pol = 1'b1;
        frame_sync_cfg = 8'h30;
        {clamp_cfg, clock_cfg, power_cfg} = 24'hC00014;
        slicer_thr_code = 5'h0F;
        clamp_delay = 8'h04;
        clamp_duration = 8'h10;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        cyc(1);
        t_reset();
        t_thr();
        t_slicer();
        t_pd();
        t_ext();
        t_clamp();
        t_field();
        t_line_pol();
        final_report();
    end

    // hang limit
    always @(posedge clk) begin
        tick++;
        if (tick == 12000) begin
            n_errors++;
            final_report();
        end
    end
endmodule : scc_top_bench

`default_nettype wire
